// [rtl/sub_swap_xor_exec_unit.sv]
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module sub_swap_xor_exec_unit (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // port direction latches, selectors 5, 6, 7
    output logic [2:0][7:0] direction_latch
);

    logic [13:0] insn;
    logic [7:0] acc;
    logic flag_c;
    logic flag_dc;
    logic flag_z;
    logic illegal;
    logic [6:0] rf_index;
    logic [7:0] rf [128];
    exec_unit_pkg::phase_e phase;
    exec_unit_pkg::dec_s dec;
    exec_unit_pkg::dec_s next_dec;
    logic [7:0] opnd;
    logic [7:0] res;
    logic res_c;
    logic res_dc;
    logic res_z;
    logic [7:0] next_res;
    logic next_c;
    logic next_dc;
    logic next_z;
    logic aw_full;
    logic w_full;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;
    logic [31:0] merged;

    // byte-lane merge of a write into the old contents
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] din,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    // a - b with carry out and nibble carry out, inverted borrows
    function automatic logic [9:0] sub8(input logic [7:0] a,
                                        input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        return {full[8], low[4], full[7:0]};
    endfunction : sub8

    // write commit and register decode
    wire busy = (phase != exec_unit_pkg::PH_IDLE);
    wire wr_commit = aw_full && w_full && !bvalid;
    wire wr_insn = wr_commit && (wr_addr == exec_unit_pkg::OFF_INSN);
    wire wr_acc = wr_commit && (wr_addr == exec_unit_pkg::OFF_ACC);
    wire wr_status = wr_commit && (wr_addr == exec_unit_pkg::OFF_STATUS);
    wire wr_index = wr_commit && (wr_addr == exec_unit_pkg::OFF_RF_INDEX);
    wire wr_rfdata = wr_commit && (wr_addr == exec_unit_pkg::OFF_RF_DATA);
    wire wr_dir = wr_commit && (wr_addr == exec_unit_pkg::OFF_DIR);
    wire wr_mapped = wr_insn || wr_acc || wr_status || wr_index
                     || wr_rfdata || wr_dir;
    // software may not disturb operands while an instruction runs
    wire start = wr_insn && !busy;
    wire sw_acc = wr_acc && !busy;
    wire sw_flags = wr_status && !busy;
    wire sw_rf = wr_rfdata && !busy;
    wire q4 = (phase == exec_unit_pkg::PH_Q4);
    wire op_sub = (dec.op == exec_unit_pkg::OP_REG_MINUS_ACC)
                  || (dec.op == exec_unit_pkg::OP_LIT_MINUS_ACC);
    wire op_xor = (dec.op == exec_unit_pkg::OP_REG_ACC_PARITY)
                  || (dec.op == exec_unit_pkg::OP_ACC_LIT_PARITY);
    wire op_reg = (dec.op == exec_unit_pkg::OP_REG_MINUS_ACC)
                  || (dec.op == exec_unit_pkg::OP_NIBBLE_EXCHANGE)
                  || (dec.op == exec_unit_pkg::OP_REG_ACC_PARITY);
    wire op_lit = (dec.op == exec_unit_pkg::OP_LIT_MINUS_ACC)
                  || (dec.op == exec_unit_pkg::OP_ACC_LIT_PARITY);
    wire exec_acc = q4 && (op_lit || (op_reg && !dec.dest));
    wire exec_rf = q4 && op_reg && dec.dest;
    wire exec_dir = q4 && (dec.op == exec_unit_pkg::OP_DIRECTION_LOAD);
    wire [1:0] dir_sel = 2'(dec.faddr[2:0] - exec_unit_pkg::DIR_SEL_MIN);
    assign merged = merge(rd_word_w(wr_addr), wr_data, wr_strb);

    // current word of a register, for read data and byte merging
    function automatic logic [31:0] rd_word_w(input logic [7:0] a);
        logic [31:0] w;
        w = '0;
        if (a == exec_unit_pkg::OFF_INSN) begin
            w[13:0] = insn;
        end else if (a == exec_unit_pkg::OFF_ACC) begin
            w[7:0] = acc;
        end else if (a == exec_unit_pkg::OFF_STATUS) begin
            w[exec_unit_pkg::ST_C] = flag_c;
            w[exec_unit_pkg::ST_DC] = flag_dc;
            w[exec_unit_pkg::ST_Z] = flag_z;
            w[exec_unit_pkg::ST_BUSY] = busy;
            w[exec_unit_pkg::ST_ILLEGAL] = illegal;
        end else if (a == exec_unit_pkg::OFF_RF_INDEX) begin
            w[6:0] = rf_index;
        end else if (a == exec_unit_pkg::OFF_RF_DATA) begin
            w[7:0] = rf[rf_index];
        end else if (a == exec_unit_pkg::OFF_DIR) begin
            w[23:0] = direction_latch;
        end
        return w;
    endfunction : rd_word_w

    // read decode; unmapped reads return zero with slverr
    assign rd_word = rd_word_w(araddr);
    assign rd_resp = (araddr == exec_unit_pkg::OFF_INSN
                      || araddr == exec_unit_pkg::OFF_ACC
                      || araddr == exec_unit_pkg::OFF_STATUS
                      || araddr == exec_unit_pkg::OFF_RF_INDEX
                      || araddr == exec_unit_pkg::OFF_RF_DATA
                      || araddr == exec_unit_pkg::OFF_DIR)
                     ? exec_unit_pkg::RESP_OKAY : exec_unit_pkg::RESP_SLVERR;

    // instruction decode, unknown patterns fall to none
    always_comb begin
        next_dec.op = exec_unit_pkg::OP_NONE;
        next_dec.dest = insn[7];
        next_dec.faddr = insn[6:0];
        next_dec.lit = insn[7:0];
        if (insn[13:8] == exec_unit_pkg::OPC_REG_MINUS_ACC) begin
            next_dec.op = exec_unit_pkg::OP_REG_MINUS_ACC;
        end else if (insn[13:8] == exec_unit_pkg::OPC_NIBBLE_EXCHANGE) begin
            next_dec.op = exec_unit_pkg::OP_NIBBLE_EXCHANGE;
        end else if (insn[13:8] == exec_unit_pkg::OPC_REG_ACC_PARITY) begin
            next_dec.op = exec_unit_pkg::OP_REG_ACC_PARITY;
        end else if (insn[13:8] == exec_unit_pkg::OPC_ACC_LIT_PARITY) begin
            next_dec.op = exec_unit_pkg::OP_ACC_LIT_PARITY;
        end else if (insn[13:9] == exec_unit_pkg::OPC_LIT_MINUS_ACC) begin
            next_dec.op = exec_unit_pkg::OP_LIT_MINUS_ACC;
        end else if (insn[13:3] == exec_unit_pkg::OPC_DIRECTION_LOAD
                     && insn[2:0] >= exec_unit_pkg::DIR_SEL_MIN) begin
            next_dec.op = exec_unit_pkg::OP_DIRECTION_LOAD;
        end
    end

    // process phase: result and flags from operand and accumulator
    always_comb begin
        next_res = 8'h00;
        next_c = flag_c;
        next_dc = flag_dc;
        next_z = flag_z;
        case (dec.op)
            exec_unit_pkg::OP_REG_MINUS_ACC,
            exec_unit_pkg::OP_LIT_MINUS_ACC: begin
                // opnd holds the register or the literal
                // inverted borrows give carry and digit
                {next_c, next_dc, next_res} = sub8(opnd, acc);
                next_z = (next_res == 8'h00);
            end
            exec_unit_pkg::OP_NIBBLE_EXCHANGE: begin
                next_res = {opnd[3:0], opnd[7:4]};
            end
            exec_unit_pkg::OP_ACC_LIT_PARITY,
            exec_unit_pkg::OP_REG_ACC_PARITY: begin
                next_res = acc ^ opnd;
                next_z = (next_res == 8'h00);
            end
            default: begin
                next_res = acc;
            end
        endcase
    end

    // q1 decode, q2 operand read, q3 process, q4 write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= exec_unit_pkg::PH_IDLE;
        end else begin
            case (phase)
                exec_unit_pkg::PH_IDLE: begin
                    if (start) begin
                        phase <= exec_unit_pkg::PH_Q1;
                    end
                end
                exec_unit_pkg::PH_Q1: phase <= exec_unit_pkg::PH_Q2;
                exec_unit_pkg::PH_Q2: phase <= exec_unit_pkg::PH_Q3;
                exec_unit_pkg::PH_Q3: phase <= exec_unit_pkg::PH_Q4;
                default: phase <= exec_unit_pkg::PH_IDLE;
            endcase
        end
    end

    // pipeline holding registers, data only
    always_ff @(posedge aclk) begin
        if (phase == exec_unit_pkg::PH_Q1) begin
            dec <= next_dec;
        end
        if (phase == exec_unit_pkg::PH_Q2) begin
            opnd <= op_lit ? dec.lit : rf[dec.faddr];
        end
        if (phase == exec_unit_pkg::PH_Q3) begin
            {res, res_c, res_dc, res_z} <= {next_res, next_c, next_dc, next_z};
        end
    end

    // instruction, accumulator, index, flags; execution wins over software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            insn <= exec_unit_pkg::INSN_RST;
            acc <= exec_unit_pkg::ACC_RST;
            rf_index <= exec_unit_pkg::INDEX_RST;
            {flag_c, flag_dc, flag_z, illegal} <= 4'h0;
        end else begin
            if (start) insn <= merged[13:0];
            if (wr_index) rf_index <= merged[6:0];
            if (exec_acc) begin
                acc <= res;
            end else if (sw_acc) begin
                acc <= merged[7:0];
            end
            if (q4) begin
                // only the flags each instruction owns are replaced
                {flag_c, flag_dc, flag_z} <= {res_c, res_dc, res_z};
            end else if (sw_flags) begin
                flag_c <= merged[exec_unit_pkg::ST_C];
                flag_dc <= merged[exec_unit_pkg::ST_DC];
                flag_z <= merged[exec_unit_pkg::ST_Z];
            end
            // sticky, write one to clear, a new event wins
            if (phase == exec_unit_pkg::PH_Q1
                && next_dec.op == exec_unit_pkg::OP_NONE) begin
                illegal <= 1'b1;
            // held write word, the bus data may already have moved on
            end else if (wr_status && wr_data[exec_unit_pkg::ST_ILLEGAL]
                         && wr_strb[0]) begin
                illegal <= 1'b0;
            end
        end
    end

    // register file; left unreset, it is plain data storage
    always_ff @(posedge aclk) begin
        if (exec_rf) begin
            rf[dec.faddr] <= res;
        end else if (sw_rf) begin
            rf[rf_index] <= merged[7:0];
        end
    end

    // direction latches, loaded only by the instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            direction_latch <= {3{exec_unit_pkg::DIR_RST}};
        end else if (exec_dir) begin
            direction_latch[dir_sel] <= acc;
        end
    end

    // axi write channels, either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {aw_full, w_full, bvalid} <= 3'b000;
            {awready, wready} <= 2'b11;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            bresp <= exec_unit_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                {aw_full, awready} <= 2'b10;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                {w_full, wready} <= 2'b10;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_commit) begin
                bvalid <= 1'b1;
                bresp <= wr_mapped ? exec_unit_pkg::RESP_OKAY
                                   : exec_unit_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                {aw_full, w_full, awready, wready} <= 4'b0011;
            end
        end
    end

    // axi read channel, data registered at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {arready, rvalid} <= 2'b10;
            rdata <= 32'h0000_0000;
            rresp <= exec_unit_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            {arready, rvalid} <= 2'b01;
            rdata <= rd_word;
            rresp <= rd_resp;
        end else if (rvalid && rready) begin
            {arready, rvalid} <= 2'b10;
        end
    end

    // checks; helpers recompute results independently of sub8
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    localparam int LAST_PHASE = exec_unit_pkg::PHASE_COUNT - 1;
    logic [2:0] ph_cnt;
    always_ff @(posedge aclk) begin
        ph_cnt <= (phase == exec_unit_pkg::PH_IDLE) ? 3'h0 : 3'(ph_cnt + 3'h1);
    end
    wire [7:0] chk_diff = opnd - acc;
    wire chk_ge = (opnd >= acc);
    wire chk_lo_ge = (opnd[3:0] >= acc[3:0]);
    wire [7:0] chk_swap = {opnd[3:0], opnd[7:4]};
    wire [7:0] chk_xor = acc ^ opnd;
    wire [2:0] flags = {flag_c, flag_dc, flag_z};
    wire q4_sub_reg = q4 && dec.op == exec_unit_pkg::OP_REG_MINUS_ACC;

    sequence s_phases;
        phase == exec_unit_pkg::PH_Q1 ##1 phase == exec_unit_pkg::PH_Q2
        ##1 phase == exec_unit_pkg::PH_Q3 ##1 phase == exec_unit_pkg::PH_Q4
        ##1 phase == exec_unit_pkg::PH_IDLE;
    endsequence
    a_four_phase: assert property (start |=> s_phases)
        else $error("instruction did not take four phases");
    a_phase_count: assert property (q4 |-> ph_cnt == LAST_PHASE)
        else $error("write phase at wrong count");
    a_sub_to_acc: assert property (q4_sub_reg && !dec.dest |=>
        acc == $past(chk_diff))
        else $error("register minus accumulator wrong");
    a_dest_reg: assert property (q4_sub_reg && dec.dest |=>
        rf[dec.faddr] == $past(chk_diff) && $stable(acc))
        else $error("result not written back to register");
    a_carry_sub: assert property (q4 && op_sub |=>
        flag_c == $past(chk_ge))
        else $error("subtract carry wrong");
    a_zero_sub: assert property (q4 && op_sub |=>
        flag_z == ($past(opnd) == $past(acc)))
        else $error("subtract zero flag wrong");
    a_digit_sub: assert property (q4 && op_sub |=>
        flag_dc == $past(chk_lo_ge))
        else $error("subtract digit flag wrong");
    a_nibble_swap: assert property (q4 && !dec.dest
        && dec.op == exec_unit_pkg::OP_NIBBLE_EXCHANGE |=>
        acc == $past(chk_swap) && $stable(flags))
        else $error("nibble exchange wrong or flags moved");
    a_dir_load: assert property (exec_dir |=>
        direction_latch[$past(dir_sel)] == $past(acc) && $stable(flags))
        else $error("direction latch load wrong");
    a_xor_lit: assert property (q4
        && dec.op == exec_unit_pkg::OP_ACC_LIT_PARITY |=>
        acc == $past(chk_xor) && flag_z == ($past(chk_xor) == 8'h00)
        && $stable(flag_c) && $stable(flag_dc))
        else $error("literal xor wrong");
    a_xor_reg: assert property (q4 && dec.dest
        && dec.op == exec_unit_pkg::OP_REG_ACC_PARITY |=>
        rf[dec.faddr] == $past(chk_xor) && $stable(flag_c))
        else $error("register xor wrong");
    a_lit_sub: assert property (q4
        && dec.op == exec_unit_pkg::OP_LIT_MINUS_ACC |=>
        acc == $past(chk_diff))
        else $error("literal minus accumulator wrong");

endmodule : sub_swap_xor_exec_unit

// [rtl/exec_unit_pkg.sv]
package exec_unit_pkg;

    // clock and instruction timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int INSN_CYCLE_NS = 400;
    localparam int PHASE_COUNT = INSN_CYCLE_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] OFF_INSN = 8'h00;
    localparam logic [7:0] OFF_ACC = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RF_INDEX = 8'h0c;
    localparam logic [7:0] OFF_RF_DATA = 8'h10;
    localparam logic [7:0] OFF_DIR = 8'h14;

    // status bit positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_ILLEGAL = 4;

    // values after reset
    localparam logic [13:0] INSN_RST = 14'h0000;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [6:0] INDEX_RST = 7'h00;

    // opcode patterns
    localparam logic [5:0] OPC_REG_MINUS_ACC = 6'h02;
    localparam logic [5:0] OPC_NIBBLE_EXCHANGE = 6'h0e;
    localparam logic [5:0] OPC_REG_ACC_PARITY = 6'h06;
    localparam logic [5:0] OPC_ACC_LIT_PARITY = 6'h3a;
    localparam logic [4:0] OPC_LIT_MINUS_ACC = 5'h1e;
    localparam logic [10:0] OPC_DIRECTION_LOAD = 11'h00c;
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_Q1 = 3'b001,
        PH_Q2 = 3'b010,
        PH_Q3 = 3'b011,
        PH_Q4 = 3'b100
    } phase_e;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_REG_MINUS_ACC = 3'b001,
        OP_LIT_MINUS_ACC = 3'b010,
        OP_NIBBLE_EXCHANGE = 3'b011,
        OP_ACC_LIT_PARITY = 3'b100,
        OP_REG_ACC_PARITY = 3'b101,
        OP_DIRECTION_LOAD = 3'b110
    } op_e;

    typedef struct packed {
        op_e op;
        logic dest;
        logic [6:0] faddr;
        logic [7:0] lit;
    } dec_s;

endpackage : exec_unit_pkg

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // clock, reset and bus drive
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [2:0][7:0] direction_latch;
    int n_errors = 0;
    int check_count = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #50 aclk = ~aclk;

    sub_swap_xor_exec_unit sub_swap_xor_exec_unit_i (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .direction_latch(direction_latch)
    );

    task automatic tally_and_finish();
        if (n_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // value compare
    task automatic chk_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_val

    // response code compare
    task automatic chk_resp(input string nm, input logic [1:0] e,
                            input logic [1:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_resp

    // starts one edge late so ready lines never see two drives at once
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                             output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                            output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_read

    // start an instruction, see it busy, then wait for completion
    task automatic execute(input logic [13:0] insn);
        logic [31:0] v;
        logic [1:0] rs;
        int n;
        axi_write(exec_unit_pkg::OFF_INSN, {18'h0_0000, insn}, rs);
        axi_read(exec_unit_pkg::OFF_STATUS, v, rs);
        chk_val("busy", 32'h0000_0001, {31'h0, v[3]});
        n = 0;
        while (v[3] !== 1'b0 && n < 20) begin
            axi_read(exec_unit_pkg::OFF_STATUS, v, rs);
            n++;
        end
        chk_val("idle", 32'h0000_0000, {31'h0, v[3]});
    endtask : execute

    // preload operands, run, compare accumulator, register and flags
    task automatic run_case(input logic [13:0] insn, input logic [7:0] rf,
                            input logic [7:0] acc, input logic [2:0] st,
                            input logic [7:0] eacc, input logic [7:0] erf,
                            input logic [2:0] est);
        logic [31:0] v;
        logic [1:0] rs;
        axi_write(exec_unit_pkg::OFF_RF_INDEX, {25'h0, insn[6:0]}, rs);
        axi_write(exec_unit_pkg::OFF_RF_DATA, {24'h0, rf}, rs);
        axi_write(exec_unit_pkg::OFF_ACC, {24'h0, acc}, rs);
        axi_write(exec_unit_pkg::OFF_STATUS, {29'h0, st}, rs);
        execute(insn);
        axi_read(exec_unit_pkg::OFF_ACC, v, rs);
        chk_val("acc", {24'h0, eacc}, v);
        axi_read(exec_unit_pkg::OFF_RF_DATA, v, rs);
        chk_val("reg", {24'h0, erf}, v);
        axi_read(exec_unit_pkg::OFF_STATUS, v, rs);
        chk_val("flags", {29'h0, est}, {29'h0, v[2:0]});
    endtask : run_case

    // watchdog, well beyond the expected several hundred cycles
    initial begin
        #2000000;
        n_errors++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(exec_unit_pkg::OFF_ACC, d, r);
        chk_val("acc reset", 32'h0000_0000, d);
        axi_read(exec_unit_pkg::OFF_DIR, d, r);
        chk_val("dir reset", 32'h00ff_ffff, d);
        // unmapped places answer with an error
        axi_read(8'h20, d, r);
        chk_resp("rd resp", exec_unit_pkg::RESP_SLVERR, r);
        chk_val("rd zero", 32'h0000_0000, d);
        axi_write(8'h24, 32'h0000_00ff, r);
        chk_resp("wr resp", exec_unit_pkg::RESP_SLVERR, r);
        // lane 0 off: the accumulator must keep its value
        wstrb <= 4'he;
        axi_write(exec_unit_pkg::OFF_ACC, 32'h0000_00aa, r);
        chk_resp("wr okay", exec_unit_pkg::RESP_OKAY, r);
        wstrb <= 4'hf;
        axi_read(exec_unit_pkg::OFF_ACC, d, r);
        chk_val("acc strobe", 32'h0000_0000, d);
        // register minus accumulator: positive, zero, negative
        run_case(14'h0281, 8'h03, 8'h02, 3'h0, 8'h02, 8'h01, 3'h3);
        run_case(14'h0281, 8'h02, 8'h02, 3'h0, 8'h02, 8'h00, 3'h7);
        run_case(14'h0281, 8'h01, 8'h02, 3'h7, 8'h02, 8'hff, 3'h0);
        run_case(14'h0205, 8'h10, 8'h01, 3'h0, 8'h0f, 8'h10, 3'h1);
        // literal minus accumulator, both encodings
        run_case(14'h3c02, 8'h55, 8'h01, 3'h0, 8'h01, 8'h55, 3'h3);
        run_case(14'h3d02, 8'h55, 8'h02, 3'h0, 8'h00, 8'h55, 3'h7);
        run_case(14'h3c02, 8'h55, 8'h03, 3'h7, 8'hff, 8'h55, 3'h0);
        // nibble exchange to each destination
        run_case(14'h0e03, 8'ha5, 8'h00, 3'h5, 8'h5a, 8'ha5, 3'h5);
        run_case(14'h0e83, 8'ha5, 8'h11, 3'h2, 8'h11, 8'h5a, 3'h2);
        // parity with literal and with register
        run_case(14'h3aaf, 8'h00, 8'hb5, 3'h3, 8'h1a, 8'h00, 3'h3);
        run_case(14'h3ab5, 8'h00, 8'hb5, 3'h0, 8'h00, 8'h00, 3'h4);
        run_case(14'h0681, 8'haf, 8'hb5, 3'h4, 8'hb5, 8'h1a, 3'h0);
        run_case(14'h0601, 8'hb5, 8'hb5, 3'h3, 8'h00, 8'hb5, 3'h7);
        // direction latches 5..7, then selector 4 must do nothing
        run_case(14'h0065, 8'h77, 8'h12, 3'h5, 8'h12, 8'h77, 3'h5);
        run_case(14'h0066, 8'h77, 8'h34, 3'h2, 8'h34, 8'h77, 3'h2);
        run_case(14'h0067, 8'h77, 8'h56, 3'h0, 8'h56, 8'h77, 3'h0);
        run_case(14'h0064, 8'h77, 8'h99, 3'h1, 8'h99, 8'h77, 3'h1);
        axi_read(exec_unit_pkg::OFF_DIR, d, r);
        chk_val("dir", 32'h0056_3412, d);
        chk_val("latch pins", 32'h0056_3412, {8'h00, direction_latch});
        chk_resp("dir resp", exec_unit_pkg::RESP_OKAY, r);
        // selector 4 was refused, so the sticky illegal bit is up
        axi_read(exec_unit_pkg::OFF_STATUS, d, r);
        chk_val("illegal", 32'h0000_0001, {31'h0, d[4]});
        axi_write(exec_unit_pkg::OFF_STATUS, 32'h0000_0010, r);
        axi_read(exec_unit_pkg::OFF_STATUS, d, r);
        chk_val("status clear", 32'h0000_0000, d);
        tally_and_finish();
    end
endmodule : tb_top
